// ===== shared/monitor_defines.svh
// Constants for the sample monitoring RAM block: offsets, fields, sizes and counts.
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH
// Register word offsets (word addresses on Avalon).
`define REG_LOWER_BOUND 4'h0
`define REG_UPPER_BOUND 4'h1
`define REG_MULTIPLIER 4'h2
`define REG_DURATION 4'h3
`define REG_A_CONTROL 4'h4
`define REG_B_CONTROL 4'h5
`define REG_A_POINTER 4'h6
`define REG_B_POINTER 4'h7
`define REG_A_DATA 4'h8
`define REG_B_DATA 4'h9
// Control register fields.
`define CTL_MODE_LSB 0
`define CTL_TAP_LSB 2
`define CTL_FUNC_LSB 5
`define CTL_CLEAR_BIT 7
`define CTL_START_BIT 8
`define CTL_BUSY_BIT 9
// Sizes and counts.
`define MEM_WORDS 2048
`define PTR_MAX 11'h7ff
`define BIN_COUNT 1024
`define BLOCK_SAMPLES 17'h10000
`define SCALE_SHIFT 15
`endif

// ===== shared/monitor_pkg.sv
// Types for the sample monitoring RAM block.
package monitor_pkg;
  typedef enum logic [1:0] {MODE_OFF, MODE_CAPTURE, MODE_HIST} mode_t;
  typedef enum logic [1:0] {FN_I, FN_Q, FN_MAG} func_t;
  typedef enum {ST_IDLE, ST_CLEAR, ST_CAPTURE, ST_HIST_READ, ST_HIST_WRITE} state_t;
  typedef struct packed {
    logic [15:0] ctl;
    logic [10:0] ptr;
    state_t st;
    logic [10:0] waddr;
    logic [16:0] blk_cnt;
    logic [15:0] blk_done;
    logic [9:0] bin;
    logic cap_q;
    logic [15:0] q_hold;
  } unit_t;
  typedef struct packed {
    logic [15:0] lower;
    logic [15:0] upper;
    logic [15:0] mult;
    logic [15:0] duration;
    logic waitreq;
    logic rd_pend;
    logic [31:0] rdata;
    logic rvalid;
  } top_t;
endpackage

// ===== rtl/monitor_ram.sv
// Two sample monitoring RAM units with capture, histogram and Avalon register access.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "monitor_defines.svh"
////////////////////////
// One monitoring unit: source selection, function generator, memory and control.
// The histogram update is a read-modify-write over two cycles, so the unit relies
// on samples arriving no closer than every third clock.
module monitor_unit (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Samples from the five taps, already synchronous.
  input wire logic [5*18-1:0] tap_i,
  input wire logic [5*18-1:0] tap_q,
  input wire logic sample_valid,
  // Shared histogram settings.
  input wire logic signed [15:0] lower,
  input wire logic signed [15:0] upper,
  input wire logic signed [15:0] mult,
  input wire logic [15:0] duration,
  // Register access for this unit.
  input wire logic ctl_wr,
  input wire logic ptr_wr,
  input wire logic data_acc,
  input wire logic data_wr,
  input wire logic [15:0] wdata,
  output logic [15:0] ctl_rd,
  output logic [10:0] ptr_rd,
  output logic [15:0] mem_rd,
  output logic host_busy
);
  // Unit state, memory array and the function generator's working values.
  monitor_pkg::unit_t s_q, s_d;
  logic [15:0] mem [0:`MEM_WORDS-1];
  logic [15:0] rd_q;
  logic mem_we;
  logic [10:0] mem_wa;
  logic [15:0] mem_wd;
  logic [2:0] tap;
  logic [17:0] si, sq;
  logic signed [17:0] fi, fq;
  logic [35:0] mag;
  logic signed [15:0] fval;
  logic signed [16:0] diff;
  logic signed [33:0] prod;
  logic in_range;
  logic [31:0] cnt;
  logic [15:0] hi_word, lo_word;

  // Tap selection and function generator.
  always_comb begin
    // Tap codes above four fall back to the input tap instead of reading off the bus.
    tap = s_q.ctl[`CTL_TAP_LSB +: 3];
    if (tap > 3'h4) begin
      tap = 3'h0;
    end
    si = tap_i[tap*18 +: 18];
    sq = tap_q[tap*18 +: 18];
    fi = si;
    fq = sq;
    // Both operands are widened first, so the squares cannot wrap at 18 bits.
    mag = 36'(fi) * 36'(fi) + 36'(fq) * 36'(fq);
    case (monitor_pkg::func_t'(s_q.ctl[`CTL_FUNC_LSB +: 2]))
      monitor_pkg::FN_I: fval = si[17:2];
      monitor_pkg::FN_Q: fval = sq[17:2];
      monitor_pkg::FN_MAG: fval = mag[35:20];
      default: fval = si[17:2];
    endcase
    in_range = (fval >= lower) && (fval <= upper);
    diff = 17'(fval) - 17'(lower);
    // Widen before the product; a 17 by 16 bit result would otherwise be cut short.
    prod = 34'(diff) * 34'(mult);
  end

  // Read-modify-write word pair for the histogram bin counter.
  // The high word lands one cycle before the low word is formed, so a carry out
  // of the low half is already in the high word and is never counted twice.
  always_comb begin
    cnt = {mem[{s_q.bin, 1'b0}], mem[{s_q.bin, 1'b1}]} + 32'h1;
    hi_word = cnt[31:16];
    lo_word = cnt[15:0];
  end

  ////////////////////////
  // Next state of the unit.
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_wa = s_q.ptr;
    mem_wd = wdata;
    s_d.cap_q = 1'b0;
    if (ctl_wr) begin
      // Only the defined control bits are kept; the rest read back as zero.
      s_d.ctl = 16'(wdata[`CTL_START_BIT:0]);
    end
    if (ptr_wr) begin
      s_d.ptr = wdata[10:0];
    end
    if (data_acc) begin
      s_d.ptr = (s_q.ptr == `PTR_MAX) ? 11'h000 : s_q.ptr + 11'h001;
      mem_we = data_wr;
    end
    case (s_q.st)
      monitor_pkg::ST_IDLE: begin
        // Clear has priority over start when both bits arrive together.
        if (ctl_wr && wdata[`CTL_CLEAR_BIT]) begin
          s_d.st = monitor_pkg::ST_CLEAR;
          s_d.waddr = 11'h000;
        end else if (ctl_wr && wdata[`CTL_START_BIT]) begin
          s_d.waddr = 11'h000;
          s_d.blk_cnt = 17'h00000;
          s_d.blk_done = 16'h0000;
          case (monitor_pkg::mode_t'(wdata[`CTL_MODE_LSB +: 2]))
            monitor_pkg::MODE_CAPTURE: s_d.st = monitor_pkg::ST_CAPTURE;
            monitor_pkg::MODE_HIST: s_d.st = monitor_pkg::ST_HIST_READ;
            default: s_d.st = monitor_pkg::ST_IDLE;
          endcase
        end
      end
      monitor_pkg::ST_CLEAR: begin
        // One word per clock: a clear takes 2048 cycles and holds off the data port.
        mem_we = 1'b1;
        mem_wa = s_q.waddr;
        mem_wd = 16'h0000;
        s_d.waddr = s_q.waddr + 11'h001;
        if (s_q.waddr == `PTR_MAX) begin
          s_d.st = monitor_pkg::ST_IDLE;
        end
      end
      monitor_pkg::ST_CAPTURE: begin
        // I goes in first, Q in the following cycle. The Q half is taken in the
        // sample's own cycle and held, because the taps move on right after it.
        if (s_q.cap_q) begin
          mem_we = 1'b1;
          mem_wa = s_q.waddr;
          mem_wd = s_q.q_hold;
          s_d.waddr = s_q.waddr + 11'h001;
          // The unit stops by itself after the Q word at the top address.
          if (s_q.waddr == `PTR_MAX) begin
            s_d.st = monitor_pkg::ST_IDLE;
          end
        end else if (sample_valid) begin
          mem_we = 1'b1;
          mem_wa = s_q.waddr;
          mem_wd = si[17:2];
          s_d.q_hold = sq[17:2];
          s_d.waddr = s_q.waddr + 11'h001;
          s_d.cap_q = 1'b1;
        end
      end
      monitor_pkg::ST_HIST_READ: begin
        // Out-of-range values write no bin; they advance the block counter and can end the run.
        if (sample_valid) begin
          s_d.blk_cnt = s_q.blk_cnt + 17'h00001;
          if (in_range) begin
            s_d.bin = prod[`SCALE_SHIFT +: 10];
            s_d.st = monitor_pkg::ST_HIST_WRITE;
          end
          if (s_q.blk_cnt == `BLOCK_SAMPLES - 17'h00001) begin
            s_d.blk_cnt = 17'h00000;
            s_d.blk_done = s_q.blk_done + 16'h0001;
            if (s_q.blk_done + 16'h0001 >= duration && !in_range) begin
              s_d.st = monitor_pkg::ST_IDLE;
            end
          end
        end
      end
      monitor_pkg::ST_HIST_WRITE: begin
        // Two cycles per bin; samples arrive no closer than every third clock.
        mem_we = 1'b1;
        mem_wa = {s_q.bin, s_q.cap_q};
        mem_wd = s_q.cap_q ? lo_word : hi_word;
        s_d.cap_q = ~s_q.cap_q;
        if (s_q.cap_q) begin
          s_d.st = (s_q.blk_done >= duration && s_q.blk_cnt == 17'h00000) ?
                   monitor_pkg::ST_IDLE : monitor_pkg::ST_HIST_READ;
        end
      end
      default: s_d.st = monitor_pkg::ST_IDLE;
    endcase
    // Turning the mode off ends a capture or a histogram run at a clean point: a
    // bin update in flight and the Q half of a captured pair finish first, so no
    // word is left half written. Without this a histogram with a long duration
    // would hold the data port off for as long as it runs.
    if (monitor_pkg::mode_t'(s_d.ctl[`CTL_MODE_LSB +: 2]) == monitor_pkg::MODE_OFF) begin
      if (s_d.st == monitor_pkg::ST_HIST_READ) begin
        s_d.st = monitor_pkg::ST_IDLE;
      end
      if (s_d.st == monitor_pkg::ST_CAPTURE && !s_d.cap_q) begin
        s_d.st = monitor_pkg::ST_IDLE;
      end
    end
    if (s_q.st == monitor_pkg::ST_HIST_WRITE && !s_q.cap_q) begin
      // The first write cycle stores the high word at the even address.
      mem_wd = hi_word;
    end
  end

  ////////////////////////
  // Memory port; the low word write reads the unchanged low half.
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    rd_q <= mem[s_q.ptr];
  end

  // State register.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Host view of the unit. Busy covers every active state, but only clearing
  // and histogram accumulation stall the data port.
  always_comb begin
    ctl_rd = s_q.ctl;
    ctl_rd[`CTL_BUSY_BIT] = (s_q.st != monitor_pkg::ST_IDLE);
    ptr_rd = s_q.ptr;
    mem_rd = rd_q;
    host_busy = (s_q.st != monitor_pkg::ST_IDLE) && (s_q.st != monitor_pkg::ST_CAPTURE);
  end
endmodule

////////////////////////
// Top level: input synchronisers, the two units and the Avalon register file.
// Settings shared by both units live here; each unit owns its control,
// pointer and memory.
module monitor_ram (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Datapath taps: input, then after stage one to four.
  input wire logic [5*18-1:0] tap_i,
  input wire logic [5*18-1:0] tap_q,
  input wire logic sample_valid,
  // Avalon-MM slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  monitor_pkg::top_t t_q, t_d;
  logic [5*18-1:0] ti_m, ti_s, tq_m, tq_s;
  logic sv_m, sv_s;
  logic [1:0] ctl_wr, ptr_wr, data_acc;
  logic [15:0] ctl_rd [0:1];
  logic [10:0] ptr_rd [0:1];
  logic [15:0] mem_rd [0:1];
  logic [1:0] busy;
  logic req;

  ////////////////////////
  // Two-stage synchronisers on the datapath inputs.
  // The taps and their strobe share one delay, so a sample stays aligned with its flag.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ti_m <= '0;
      ti_s <= '0;
      tq_m <= '0;
      tq_s <= '0;
      sv_m <= 1'b0;
      sv_s <= 1'b0;
    end else begin
      ti_m <= tap_i;
      ti_s <= ti_m;
      tq_m <= tap_q;
      tq_s <= tq_m;
      sv_m <= sample_valid;
      sv_s <= sv_m;
    end
  end

  ////////////////////////
  // Two independent units sharing the histogram settings.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_unit
      monitor_unit u_unit (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .tap_i(ti_s),
        .tap_q(tq_s),
        .sample_valid(sv_s),
        .lower(t_q.lower),
        .upper(t_q.upper),
        .mult(t_q.mult),
        .duration(t_q.duration),
        .ctl_wr(ctl_wr[g]),
        .ptr_wr(ptr_wr[g]),
        .data_acc(data_acc[g]),
        .data_wr(write),
        .wdata(writedata[15:0]),
        .ctl_rd(ctl_rd[g]),
        .ptr_rd(ptr_rd[g]),
        .mem_rd(mem_rd[g]),
        .host_busy(busy[g])
      );
    end
  endgenerate

  ////////////////////////
  // Accesses complete one cycle after they are first seen; data port stalls while busy.
  // A stalled master simply keeps its request up; nothing is taken until the unit is idle.
  always_comb begin
    t_d = t_q;
    req = (read || write) && t_q.waitreq;
    ctl_wr = '0;
    ptr_wr = '0;
    data_acc = '0;
    t_d.waitreq = 1'b1;
    if (req) begin
      case (address)
        `REG_A_DATA: t_d.waitreq = busy[0];
        `REG_B_DATA: t_d.waitreq = busy[1];
        default: t_d.waitreq = 1'b0;
      endcase
    end
    if (req && !t_d.waitreq && write) begin
      case (address)
        `REG_LOWER_BOUND: t_d.lower = writedata[15:0];
        `REG_UPPER_BOUND: t_d.upper = writedata[15:0];
        `REG_MULTIPLIER: t_d.mult = writedata[15:0];
        `REG_DURATION: t_d.duration = writedata[15:0];
        `REG_A_CONTROL: ctl_wr[0] = 1'b1;
        `REG_B_CONTROL: ctl_wr[1] = 1'b1;
        `REG_A_POINTER: ptr_wr[0] = 1'b1;
        `REG_B_POINTER: ptr_wr[1] = 1'b1;
        default: t_d.rdata = t_q.rdata; // Writes never disturb the read data.
      endcase
    end
    if (req && !t_d.waitreq && read) begin
      case (address)
        `REG_LOWER_BOUND: t_d.rdata = {16'h0, t_q.lower};
        `REG_UPPER_BOUND: t_d.rdata = {16'h0, t_q.upper};
        `REG_MULTIPLIER: t_d.rdata = {16'h0, t_q.mult};
        `REG_DURATION: t_d.rdata = {16'h0, t_q.duration};
        `REG_A_CONTROL: t_d.rdata = {16'h0, ctl_rd[0]};
        `REG_B_CONTROL: t_d.rdata = {16'h0, ctl_rd[1]};
        `REG_A_POINTER: t_d.rdata = {21'h0, ptr_rd[0]};
        `REG_B_POINTER: t_d.rdata = {21'h0, ptr_rd[1]};
        `REG_A_DATA: t_d.rdata = {16'h0, mem_rd[0]};
        `REG_B_DATA: t_d.rdata = {16'h0, mem_rd[1]};
        default: t_d.rdata = 32'h0;
      endcase
    end
    if (req && !t_d.waitreq && address == `REG_A_DATA) begin
      data_acc[0] = 1'b1;
    end
    if (req && !t_d.waitreq && address == `REG_B_DATA) begin
      data_acc[1] = 1'b1;
    end
  end

  ////////////////////////
  // Register state.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t_q <= '0;
      t_q.waitreq <= 1'b1;
    end else begin
      t_q <= t_d;
    end
  end

  // Bus outputs come straight from the registered state.
  assign readdata = t_q.rdata;
  assign waitrequest = t_q.waitreq;
endmodule

// ===== tb/monitor_ram_props.sv
// Concurrent checks on the Avalon side of the sample monitor block.
`timescale 1ns/1ps
module monitor_ram_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon slave signals.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic done_rd;
  assign done_rd = read && !waitrequest;
  ////////////////////////
  // Handshake timing.
  chk_idle_wait: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low without a request");
  chk_reg_answer: assert property ((read || write) && waitrequest && address < 4'h8
    |=> !waitrequest)
    else $error("register access not answered next cycle");
  chk_low_once: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_rd_hold: assert property (!done_rd |-> $stable(readdata))
    else $error("readdata changed without a completed read");
  ////////////////////////
  // Read data shapes; a wide stale value would show in the upper bits.
  chk_unmapped_zero: assert property (done_rd && address > 4'h9 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ptr_range: assert property (done_rd && address[3:1] == 3'h3 |-> readdata[31:11] == 21'h0)
    else $error("pointer beyond 2047");
  chk_ctl_width: assert property (done_rd && address[3:1] == 3'h2 |-> readdata[31:10] == 22'h0)
    else $error("control read has stray bits");
  chk_data_width: assert property (done_rd && address[3:1] == 3'h4 |-> readdata[31:16] == 16'h0)
    else $error("data word wider than 16 bits");
  // Main scenarios reached.
  cover property (done_rd && address == 4'h8);
  cover property (done_rd && address == 4'h9);
  cover property (write && !waitrequest && address == 4'h4);
endmodule
bind monitor_ram monitor_ram_props monitor_ram_props_inst (.ref_clk(ref_clk), .rstn(rstn),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest));

// ===== tb/sample_source.sv
// Behavioural model of the cancellation datapath feeding the five taps.
`timescale 1ns/1ps
module sample_source (
  // Clock.
  input wire logic ref_clk,
  // Samples towards the monitor.
  output logic [5*18-1:0] tap_i,
  output logic [5*18-1:0] tap_q,
  output logic sample_valid
);
  // Quiet start.
  initial begin
    tap_i = '0;
    tap_q = '0;
    sample_valid = 1'b0;
  end
  // Tap k carries the sample plus 4k, so taps differ in the kept bits; between
  // samples the taps show the inverse so stale data never looks right.
  task automatic push(input logic [17:0] i, input logic [17:0] q);
    @(posedge ref_clk);
    for (int k = 0; k < 5; k++) begin
      tap_i[18*k +: 18] <= i + 18'(4 * k);
      tap_q[18*k +: 18] <= q + 18'(4 * k);
    end
    sample_valid <= 1'b1;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    tap_i <= ~tap_i;
    tap_q <= ~tap_q;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule

// ===== tb/test_snapshot_capture_histogram.sv
// Self-checking bench for the two monitoring RAM units.
`timescale 1ns/1ps
module test_snapshot_capture_histogram;
  logic ref_clk;
  logic rstn;
  logic [5*18-1:0] tap_i;
  logic [5*18-1:0] tap_q;
  logic sample_valid;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] rd;
  logic [17:0] cs;
  logic [35:0] rows [7];
  logic [15:0] hv [6];
  int num_errors;
  int comparisons;
  monitor_ram monitor_ram_inst (.ref_clk(ref_clk), .rstn(rstn), .tap_i(tap_i), .tap_q(tap_q),
    .sample_valid(sample_valid), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  sample_source sample_source_inst (.ref_clk(ref_clk), .tap_i(tap_i), .tap_q(tap_q),
    .sample_valid(sample_valid));
  ////////////////////////
  // 200 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Prints counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low.
  task automatic bus(input logic we, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= !we;
    write <= we;
    address <= a;
    writedata <= {16'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20000);
    if (n >= 20000) begin
      num_errors++;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Points a unit at an item and reads its even and odd words.
  task automatic pair(input int u, input logic [10:0] p, input logic [15:0] e0, e1);
    bus(1'b1, 4'(6 + u), {5'h0, p});
    bus(1'b0, 4'(8 + u), 16'h0);
    check("even word", {16'h0, e0}, rd);
    bus(1'b0, 4'(8 + u), 16'h0);
    check("odd word", {16'h0, e1}, rd);
  endtask
  // Polls the busy flag; a clear or capture ends on its own.
  task automatic wait_idle(input int u);
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'(4 + u), 16'h0);
      n++;
    end while (rd[9] !== 1'b0 && n < 3000);
    check("busy", 32'h0, {31'h0, rd[9]});
  endtask
  // Tap 2 value kept by capture: bits 17 to 2 after the model's offset of 8.
  function automatic logic [15:0] kept(input logic [17:0] v);
    logic [17:0] s;
    s = v + 18'h8;
    return s[17:2];
  endfunction
  ////////////////////////
  // Watchdog, far beyond the roughly 6.5k cycles the tests need.
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end
  // Main sequence.
  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    num_errors = 0;
    comparisons = 0;
    rows = '{{4'h0, 16'h8001, 16'h8001}, {4'h1, 16'h7fff, 16'h7fff}, {4'h2, 16'h4000, 16'h4000},
      {4'h3, 16'h0005, 16'h0005}, {4'h6, 16'hffff, 16'h07ff}, {4'h5, 16'hfc4c, 16'h004c},
      {4'hf, 16'h1234, 16'h0000}};
    hv = '{16'h0011, 16'h0014, 16'h0014, 16'h000f, 16'h0101, 16'h00ff};
    repeat (6) @(posedge ref_clk);
    check("reset handshake", 32'h1, {31'h0, waitrequest});
    rstn <= 1'b1;
    foreach (rows[r]) begin
      bus(1'b1, rows[r][35:32], rows[r][31:16]);
      bus(1'b0, rows[r][35:32], 16'h0);
      check("register", {16'h0, rows[r][15:0]}, rd);
    end
    // Capture 1024 pairs from tap 2; a further sample must not land.
    bus(1'b1, 4'h4, 16'h0109);
    for (int n = 0; n < 1024; n++) begin
      cs = {4'h0, n[9:0], 4'h0};
      sample_source_inst.push(cs, ~cs);
    end
    sample_source_inst.push(18'h3ffff, 18'h0);
    wait_idle(0);
    pair(0, 11'h000, kept(18'h0), kept(~18'h0));
    pair(0, 11'h7fe, kept(18'h03ff0), kept(~18'h03ff0));
    bus(1'b0, 4'h6, 16'h0);
    check("pointer wrap", 32'h0, rd);
    bus(1'b0, 4'h8, 16'h0);
    check("wrapped data", {16'h0, kept(18'h0)}, rd);
    // Clear both, then histogram: A magnitude on tap 0, B in-phase on tap 1.
    bus(1'b1, 4'h4, 16'h0080);
    bus(1'b1, 4'h5, 16'h0080);
    wait_idle(0);
    wait_idle(1);
    pair(0, 11'h000, 16'h0, 16'h0);
    bus(1'b1, 4'h0, 16'h0010);
    bus(1'b1, 4'h1, 16'h0100);
    bus(1'b1, 4'h2, 16'h4000);
    bus(1'b1, 4'h4, 16'h0142);
    bus(1'b1, 4'h5, 16'h0106);
    foreach (hv[h]) begin
      sample_source_inst.push({16'(hv[h] - 16'h1), 2'h0}, {16'(hv[h] - 16'h1), 2'h0});
    end
    sample_source_inst.push(18'h01000, 18'h01000);
    // Let the last sample pass the input synchronisers before stopping.
    repeat (8) @(posedge ref_clk);
    bus(1'b1, 4'h4, 16'h0000);
    bus(1'b1, 4'h5, 16'h0000);
    pair(1, 11'h000, 16'h0, 16'h1);
    pair(1, 11'h002, 16'h0, 16'h0);
    pair(1, 11'h004, 16'h0, 16'h2);
    pair(1, 11'h0ee, 16'h0, 16'h1);
    pair(0, 11'h010, 16'h0, 16'h1);
    // Reset in mid-run returns the settings to zero.
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    bus(1'b0, 4'h0, 16'h0);
    check("bound after reset", 32'h0, rd);
    stop_test();
  end
endmodule
